// File: eic_pkg.sv
// package: constants for the external interrupt controller
package eic_pkg;
  localparam int NUM_EXT = 8;
  localparam int NUM_LINES = NUM_EXT + 1;
  localparam int NMI_BIT = 8;
  localparam int NUM_COLS = 8;
  localparam int PRESC_W = 5;
  localparam logic [NUM_LINES-1:0] LINES_RESET = 9'h000;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [NUM_COLS-1:0] COL_ONE = 8'h01;
  localparam int CNT_W = 33;
endpackage

// File: eic_line.sv
// one interrupt line: synchroniser, filter and trigger detection
`timescale 1ns/10ps
module eic_line (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic pin_i,
  input wire logic level_mode_i,
  input wire logic edge_pol_i,
  input wire logic level_pol_i,
  input wire logic filter_i,
  input wire logic async_i,
  output logic trig_o,
  output logic wake_o
);
  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  logic sync0;
  logic sync1;
  logic [2:0] hist;
  logic prev;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync0 <= 1'b0;
      sync1 <= 1'b0;
    end
    else if (run_i)
    begin
      sync0 <= pin_i;
      sync1 <= sync0;
    end
  end
  // polarity by mode; level after filter: majority vote, or current synced pin
  wire pol = level_mode_i ? level_pol_i : edge_pol_i;
  wire vote = (hist[0] & hist[1]) | (hist[1] & hist[2]) |
              (hist[0] & hist[2]);
  wire use_filt = filter_i & ~async_i;
  wire filt_lvl = use_filt ? vote : sync1;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      hist <= eic_pkg::SYNC_RESET;
      prev <= 1'b0;
    end
    else if (run_i)
    begin
      hist <= {hist[1:0], sync1};
      prev <= filt_lvl;
    end
  end
  // edge: rising when pol set, falling when clear
  wire edge_hit = pol ? (filt_lvl & ~prev) : (~filt_lvl & prev);
  wire lvl_cond = (filt_lvl == pol);
  wire sync_trig = level_mode_i ? lvl_cond : edge_hit;
  // async path: unclocked compare, edges act as levels
  wire async_cond = (pin_i == pol);
  assign trig_o = run_i & (async_i ? async_cond : sync_trig);
  assign wake_o = async_i & async_cond;
endmodule // eic_line

// File: eic_top.sv
// top of the external interrupt controller with keypad scan
`timescale 1ns/10ps
module eic_top #(
  parameter int NUM_COLS = eic_pkg::NUM_COLS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [eic_pkg::NUM_EXT-1:0] ext_irq_pin_i,
  input wire logic nmi_pin_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] mask_set_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] mask_clear_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] flag_clear_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] line_enable_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] line_disable_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] level_mode_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] edge_pol_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] level_pol_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] filter_i,
  input wire logic [eic_pkg::NUM_LINES-1:0] async_i,
  input wire logic scan_en_i,
  input wire logic [eic_pkg::PRESC_W-1:0] scan_prescale_i,
  input wire logic debug_halt_i,
  input wire logic debug_run_i,
  output logic [eic_pkg::NUM_LINES-1:0] mask_state_o,
  output logic [eic_pkg::NUM_LINES-1:0] flag_state_o,
  output logic [eic_pkg::NUM_LINES-1:0] line_ctrl_o,
  output logic [eic_pkg::NUM_EXT-1:0] irq_o,
  output logic nmi_req_o,
  output logic wake_out_o,
  output logic [NUM_COLS-1:0] keypad_column_out_o,
  output logic [NUM_COLS-1:0] keypad_column_oe_o,
  output logic [$clog2(NUM_COLS)-1:0] scan_pins_o
);
  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  localparam int NL = eic_pkg::NUM_LINES;
  logic [NL-1:0] mask;
  logic [NL-1:0] ctrl;
  logic [NL-1:0] flag;
  logic [NL-1:0] trig;
  logic [NL-1:0] wake_v;
  wire run = ~debug_halt_i | debug_run_i;
  wire [NL-1:0] pins = {nmi_pin_i, ext_irq_pin_i};
  wire [NL-1:0] next_mask = (mask | mask_set_i) & ~mask_clear_i;
  wire [NL-1:0] next_ctrl = (ctrl | line_enable_i) & ~line_disable_i;
  // set wins over clear; disable always clears
  wire [NL-1:0] set_f = trig & ctrl & {NL{run}};
  wire [NL-1:0] next_flag = ((flag & ~flag_clear_i) | set_f) &
                            next_ctrl;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mask <= eic_pkg::LINES_RESET;
      ctrl <= eic_pkg::LINES_RESET;
      flag <= eic_pkg::LINES_RESET;
    end
    else
    begin
      mask <= next_mask;
      ctrl <= next_ctrl;
      flag <= next_flag;
    end
  end
  // ----------------------------------------------------------------
  // per-line detection
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : g_line
      eic_line u_line (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(run),
        .pin_i(pins[g]),
        .level_mode_i(level_mode_i[g]),
        .edge_pol_i(edge_pol_i[g]),
        .level_pol_i(level_pol_i[g]),
        .filter_i(filter_i[g]),
        .async_i(async_i[g]),
        .trig_o(trig[g]),
        .wake_o(wake_v[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire [NL-1:0] req = flag & mask;
  assign mask_state_o = mask;
  assign line_ctrl_o = ctrl;
  assign flag_state_o = flag & ctrl;
  assign irq_o = req[eic_pkg::NUM_EXT-1:0];
  assign nmi_req_o = req[eic_pkg::NMI_BIT];
  // wake ignores the mask so sleep can end without a cpu request
  assign wake_out_o = |((flag | wake_v) & ctrl);
  // ----------------------------------------------------------------
  // keypad scan
  // ----------------------------------------------------------------
  // one clock only: the rc clock is folded into clk_i as a counter
  logic [eic_pkg::CNT_W-1:0] cnt;
  logic [NUM_COLS-1:0] col;
  logic [$clog2(NUM_COLS)-1:0] idx;
  wire any_req = |req;
  wire [eic_pkg::CNT_W-1:0] limit =
    (eic_pkg::CNT_W'(1) << ({1'b0, scan_prescale_i} + 6'h01)) - 1'b1;
  wire step = (cnt >= limit);
  wire scan_go = scan_en_i & run & ~any_req;
  wire last = (idx == ($clog2(NUM_COLS))'(NUM_COLS - 1));
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !scan_en_i)
    begin
      cnt <= '0;
      col <= eic_pkg::COL_ONE;
      idx <= '0;
    end
    else if (scan_go)
    begin
      cnt <= step ? '0 : cnt + 1'b1;
      if (step)
      begin
        col <= {col[NUM_COLS-2:0], col[NUM_COLS-1]};
        idx <= last ? '0 : idx + 1'b1;
      end
    end
  end
  assign keypad_column_out_o = '0;
  assign keypad_column_oe_o = scan_en_i ? col : '0;
  assign scan_pins_o = idx;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_off: assert property (@(posedge clk_i)
    srst_i |=> (ctrl == '0) && (mask == '0))
    else $error("lines not disabled after reset");
  a_flag_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    (flag[0] && !flag_clear_i[0] && !line_disable_i[0]) |=> flag[0])
    else $error("flag dropped without clear");
  a_set_wins: assert property (@(posedge clk_i) disable iff (srst_i)
    (set_f[4] && flag_clear_i[4] && !line_disable_i[4]) |=> flag[4])
    else $error("event lost on clear");
  a_dis_clears: assert property (@(posedge clk_i) disable iff (srst_i)
    line_disable_i[1] |=> !flag[1] && !ctrl[1])
    else $error("disable did not clear flag");
  a_mask_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    !mask[0] |-> !irq_o[0])
    else $error("masked request leaked");
  a_mask_set: assert property (@(posedge clk_i) disable iff (srst_i)
    (mask_set_i[2] && !mask_clear_i[2]) |=> mask[2])
    else $error("mask set ignored");
  a_nmi_route: assert property (@(posedge clk_i) disable iff (srst_i)
    nmi_req_o |-> flag[eic_pkg::NMI_BIT] && ctrl[eic_pkg::NMI_BIT])
    else $error("nmi without flag");
  a_scan_pause: assert property (@(posedge clk_i) disable iff (srst_i)
    (any_req && scan_en_i) |=> $stable(col))
    else $error("scan moved during request");
  a_freeze: assert property (@(posedge clk_i) disable iff (srst_i)
    (!run && !flag_clear_i[0] && !line_disable_i[0]) |=>
    (flag[0] == $past(flag[0])))
    else $error("flag changed while frozen");
  a_one_col: assert property (@(posedge clk_i) disable iff (srst_i)
    scan_en_i |-> $onehot(keypad_column_oe_o))
    else $error("scan not one-hot");
endmodule // eic_top

// File: eic_cpu_model.sv
// model of the cpu side: latches every request it is shown
`timescale 1ns/10ps
module eic_cpu_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] irq_i,
  input wire logic nmi_i,
  output logic [8:0] taken_o
);
  // sticky like a pending latch, so a one-cycle request is never missed
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      taken_o <= 9'h000;
    else
      taken_o <= taken_o | {nmi_i, irq_i};
  end
endmodule // eic_cpu_model

// File: tb_top.sv
// self-checking testbench for the external interrupt controller
`timescale 1ns/10ps
module tb_top;
  localparam int NL = eic_pkg::NUM_LINES;
  typedef struct {logic lm, ep, lp, p0, p1, hit;} eic_row_s;
  logic clk_i, srst_i, nmi_pin_i, scan_en_i, debug_halt_i, debug_run_i;
  logic nmi_req_o, wake_out_o;
  logic [7:0] pin, irq_o, col_o, oe_o, sv;
  logic [2:0] sp;
  logic [NL-1:0] ms, mc, fc, le, ld, lm, ep, lp, fi, asy, taken;
  logic [NL-1:0] mask_o, flag_o, ctrl_o;
  int n_errors, comparisons;
  eic_row_s rows [8] = '{'{0,0,0,1,0,1}, '{0,0,0,0,1,0}, '{0,1,0,0,1,1},
    '{0,1,0,1,0,0}, '{1,0,0,1,0,1}, '{1,0,0,1,1,0}, '{1,0,1,0,1,1},
    '{1,0,1,0,0,0}};
  eic_top DUT (.clk_i, .srst_i, .ext_irq_pin_i(pin), .nmi_pin_i,
    .mask_set_i(ms), .mask_clear_i(mc), .flag_clear_i(fc),
    .line_enable_i(le), .line_disable_i(ld), .level_mode_i(lm),
    .edge_pol_i(ep), .level_pol_i(lp), .filter_i(fi), .async_i(asy),
    .scan_en_i, .scan_prescale_i(5'h00), .debug_halt_i, .debug_run_i,
    .mask_state_o(mask_o), .flag_state_o(flag_o), .line_ctrl_o(ctrl_o),
    .irq_o, .nmi_req_o, .wake_out_o, .keypad_column_out_o(col_o),
    .keypad_column_oe_o(oe_o), .scan_pins_o(sp));
  eic_cpu_model cpu (.clk_i, .srst_i, .irq_i(irq_o), .nmi_i(nmi_req_o),
    .taken_o(taken));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task strobe(input logic [NL-1:0] a, b, c, d, e);
    {ms, mc, fc, le, ld} = {a, b, c, d, e};
    step(1);
    {ms, mc, fc, le, ld} = '0;
  endtask
  task chk(input string nm, input logic [NL-1:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  // bounded far above the few hundred cycles the tests need
  initial
  begin
    #100000;
    n_errors++;
    give_verdict;
  end
  initial
  begin
    {srst_i, nmi_pin_i, scan_en_i, debug_halt_i, debug_run_i} = 5'h18;
    {ms, mc, fc, le, ld, lm, ep, lp, fi, asy} = '0;
    pin = '1;
    step(16);
    srst_i = 0;
    chk("ctrl reset", 0, ctrl_o);
    chk("mask reset", 0, mask_o);
    for (int i = 0; i < 8; i++)
    begin
      {lm[i], ep[i], lp[i]} = {rows[i].lm, rows[i].ep, rows[i].lp};
      pin[i] = rows[i].p0;
      strobe(NL'(1) << i, 0, 0, NL'(1) << i, 0);
      step(4);
      strobe(0, 0, NL'(1) << i, 0, 0);
      pin[i] = rows[i].p1;
      step(5);
      chk("row flag", NL'(rows[i].hit) << i, flag_o);
      chk("row irq", NL'(rows[i].hit) << i, NL'(irq_o));
      strobe(0, NL'(1) << i, 0, 0, NL'(1) << i);
      pin[i] = 1;
    end
    strobe(9'h001, 0, 0, 9'h001, 0);
    pin[0] = 0;
    step(2);
    chk("flag early", 0, flag_o);
    step(1);
    chk("flag on time", 9'h001, flag_o);
    pin[0] = 1;
    step(4);
    chk("irq held", 9'h001, NL'(irq_o));
    strobe(0, 0, 9'h001, 0, 0);
    chk("flag cleared", 0, flag_o);
    strobe(0, 9'h001, 0, 0, 0);
    pin[0] = 0;
    step(4);
    chk("masked flag", 9'h001, flag_o);
    chk("masked irq", 0, NL'(irq_o));
    chk("wake", 9'h001, NL'(wake_out_o));
    chk("mask", 0, mask_o);
    strobe(0, 0, 0, 0, 9'h001);
    chk("disabled flag", 0, flag_o);
    chk("ctrl", 0, ctrl_o);
    fi[1] = 1;
    strobe(9'h002, 0, 0, 9'h002, 0);
    pin[1] = 0;
    step(1);
    pin[1] = 1;
    step(6);
    chk("spike", 0, flag_o);
    pin[1] = 0;
    step(3);
    chk("filter early", 0, flag_o);
    step(2);
    chk("filter late", 9'h002, flag_o);
    strobe(0, 0, 0, 0, 9'h002);
    {asy[2], ep[2]} = 2'h2;
    strobe(9'h004, 0, 0, 9'h004, 0);
    chk("async idle", 0, NL'(wake_out_o));
    pin[2] = 0;
    #1;
    chk("async wake", 9'h001, NL'(wake_out_o));
    chk("async flag", 0, flag_o);
    step(1);
    chk("async irq", 9'h004, NL'(irq_o));
    pin[2] = 1;
    strobe(0, 0, 0, 0, 9'h004);
    lm[8] = 1;
    nmi_pin_i = 0;
    strobe(9'h100, 0, 0, 9'h100, 0);
    step(4);
    chk("nmi taken", 9'h100, taken & 9'h100);
    chk("nmi not irq", 0, NL'(irq_o));
    strobe(0, 0, 0, 0, 9'h100);
    chk("nmi off", 0, NL'(nmi_req_o));
    {ep[3], debug_halt_i} = 2'h1;
    strobe(9'h008, 0, 0, 9'h008, 0);
    pin[3] = 0;
    step(6);
    chk("frozen", 0, flag_o);
    debug_run_i = 1;
    step(4);
    chk("debug run", 9'h008, flag_o);
    {debug_halt_i, debug_run_i} = 2'h0;
    strobe(0, 0, 0, 0, 9'h1ff);
    scan_en_i = 1;
    for (int w = 0; w < 40 && oe_o !== 8'h02; w++) step(1);
    for (int k = 1; k < 10; k++)
    begin
      chk("column", NL'(8'h01 << (k % 8)), NL'(oe_o));
      chk("scan index", NL'(k % 8), NL'(sp));
      chk("column low", 0, NL'(col_o));
      step(2);
    end
    strobe(9'h010, 0, 0, 9'h010, 0);
    pin[4] = 0;
    step(4);
    sv = oe_o;
    step(6);
    chk("scan paused", NL'(sv), NL'(oe_o));
    strobe(0, 0, 9'h010, 0, 0);
    chk("set wins", 9'h010, flag_o);
    give_verdict;
  end
endmodule // tb_top
